// file: afc_dma_abort.sv
`timescale 1ns/100ps
`default_nettype none
// watches one dma channel and decides when it must be abandoned
module afc_dma_abort #(
  parameter logic [afc_pkg::TMO_W-1:0] TIMEOUT_CYC = afc_pkg::TMO_W'(afc_pkg::DMA_TIMEOUT_CYC)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // dma channel events
  input wire logic xfer_start_i,
  input wire logic xfer_done_i,
  input wire logic par_err_i,
  input wire logic bus_err_i,
  input wire logic [31:0] sys_addr_i,
  // limits programmed at initialization
  input wire logic [afc_pkg::LIMIT_W-1:0] par_limit_i,
  input wire logic [afc_pkg::LIMIT_W-1:0] bus_limit_i,
  // abort report
  output logic abort_o,
  output logic [15:0] reason_o,
  output logic [31:0] addr_o
);
  logic busy_r, busy_nxt;
  logic [afc_pkg::LIMIT_W-1:0] par_cnt_r, par_cnt_nxt, bus_cnt_r, bus_cnt_nxt;
  logic [afc_pkg::TMO_W-1:0] tmo_r, tmo_nxt;

  // counts saturate so a long burst of errors cannot wrap below the limit
  always_comb begin
    busy_nxt = busy_r;
    par_cnt_nxt = par_cnt_r;
    bus_cnt_nxt = bus_cnt_r;
    tmo_nxt = tmo_r;
    abort_o = 1'b0;
    reason_o = afc_pkg::ABORT_TIMEOUT;
    addr_o = sys_addr_i;
    if (xfer_start_i) begin
      busy_nxt = 1'b1;
      tmo_nxt = '0;
      // error counts belong to one transfer, so clean transfers never add up
      par_cnt_nxt = '0;
      bus_cnt_nxt = '0;
    end else if (busy_r) begin
      tmo_nxt = tmo_r + 1'b1;
      if (par_err_i && par_cnt_r != '1) begin
        par_cnt_nxt = par_cnt_r + 1'b1;
      end
      if (bus_err_i && bus_cnt_r != '1) begin
        bus_cnt_nxt = bus_cnt_r + 1'b1;
      end
      if (par_cnt_nxt > par_limit_i) begin
        abort_o = 1'b1;
        reason_o = afc_pkg::ABORT_PARITY;
      end else if (bus_cnt_nxt > bus_limit_i) begin
        abort_o = 1'b1;
        reason_o = afc_pkg::ABORT_BUS_ERR;
      end else if (tmo_r >= TIMEOUT_CYC - 1'b1) begin
        abort_o = 1'b1;
        reason_o = afc_pkg::ABORT_TIMEOUT;
      end
      if (xfer_done_i || abort_o) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      par_cnt_r <= '0;
      bus_cnt_r <= '0;
      tmo_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      par_cnt_r <= par_cnt_nxt;
      bus_cnt_r <= bus_cnt_nxt;
      tmo_r <= tmo_nxt;
    end
  end
endmodule
`default_nettype wire

// file: afc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the record port: loads the address, then streams the bytes
module afc_host_model (
  // clock
  input wire logic clk_i,
  // record port
  input wire logic [7:0] rdata_i,
  output logic addr_wr_o,
  output logic [15:0] addr_wdata_o,
  output logic data_rd_o
);
  initial begin
    addr_wr_o = 1'b0;
    addr_wdata_o = 16'h0000;
    data_rd_o = 1'b0;
  end
  // read data lags its strobe by two edges, so reads run back to back
  task automatic fetch(output logic [63:0] rec);
    rec = '0;
    @(posedge clk_i);
    #1 addr_wr_o = 1'b1;
    addr_wdata_o = afc_pkg::REC_BASE_ADDR;
    @(posedge clk_i);
    #1 addr_wr_o = 1'b0;
    // released bus shows junk, never the old address
    addr_wdata_o = ~afc_pkg::REC_BASE_ADDR;
    data_rd_o = 1'b1;
    for (int k = 1; k <= 9; k++) begin
      @(posedge clk_i);
      #1;
      if (k == afc_pkg::REC_BYTES) data_rd_o = 1'b0;
      if (k >= 2) rec = {rec[55:0], rdata_i};
    end
  endtask
endmodule
`default_nettype wire

// file: afc_pkg.sv
package afc_pkg;
  // ------------------------------------------------------------
  // record layout and access
  // ------------------------------------------------------------
  localparam logic [15:0] REC_BASE_ADDR = 16'h05e0;
  localparam int REC_BYTES = 8;
  localparam logic [2:0] REC_LAST_IDX = 3'h7;
  localparam logic [15:0] CAUSE_RESET = 16'h0000;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // ------------------------------------------------------------
  // cause bit positions
  // ------------------------------------------------------------
  localparam int CB_HOST_PARITY = 0;
  localparam int CB_DMA_RD_ABORT = 1;
  localparam int CB_DMA_WR_ABORT = 2;
  localparam int CB_ILLEGAL_OP = 3;
  localparam int CB_BUS_PAR_LO = 4;
  localparam int CB_BUS_PAR_HI = 9;
  localparam int CB_PROC_BUS_PAR = 4;
  localparam int BUS_PAR_SRCS = 6;
  // ------------------------------------------------------------
  // dma abort reason codes (parameter word 0)
  // ------------------------------------------------------------
  localparam logic [15:0] ABORT_TIMEOUT = 16'h0000;
  localparam logic [15:0] ABORT_PARITY = 16'h0001;
  localparam logic [15:0] ABORT_BUS_ERR = 16'h0002;
  // ------------------------------------------------------------
  // dma watchdog: 10 s at 125 MHz
  // ------------------------------------------------------------
  localparam longint DMA_TIMEOUT_MS = 10000;
  localparam longint CLK_KHZ = 125000;
  localparam longint DMA_TIMEOUT_CYC = DMA_TIMEOUT_MS * CLK_KHZ;
  localparam int LIMIT_W = 8;
  localparam int TMO_W = 32;

  typedef enum logic [1:0] {
    AFC_RUN,
    AFC_CHECKED
  } afc_state_e;
endpackage

// file: afc_rec_port.sv
`timescale 1ns/100ps
`default_nettype none
// host access port: address register plus auto-incrementing byte data register
module afc_rec_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host side
  input wire logic addr_wr_i,
  input wire logic [15:0] addr_wdata_i,
  input wire logic data_rd_i,
  // record contents, byte 0 first
  input wire logic [63:0] record_i,
  // outputs
  output logic [15:0] addr_o,
  output logic [7:0] rdata_o
);
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] offs;

  function automatic logic [7:0] rec_byte(input logic [63:0] rec, input logic [2:0] idx);
    rec_byte = rec[8*idx +: 8];
  endfunction

  always_comb begin
    addr_nxt = addr_r;
    rdata_nxt = rdata_r;
    offs = addr_r - afc_pkg::REC_BASE_ADDR;
    if (addr_wr_i) begin
      addr_nxt = addr_wdata_i;
    end else if (data_rd_i) begin
      // outside the record the port reads as zero
      if (offs < 16'(afc_pkg::REC_BYTES)) begin
        rdata_nxt = rec_byte(record_i, offs[2:0]);
      end else begin
        rdata_nxt = 8'h00;
      end
      addr_nxt = addr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= afc_pkg::ADDR_RESET;
      rdata_r <= 8'h00;
    end else begin
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign addr_o = addr_r;
  assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// file: afc_top.sv
`timescale 1ns/100ps
`default_nettype none
module afc_top #(
  parameter logic [afc_pkg::TMO_W-1:0] DMA_TIMEOUT_CYC =
    afc_pkg::TMO_W'(afc_pkg::DMA_TIMEOUT_CYC)
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // host direct access port
  input wire logic addr_wr_i,
  input wire logic [15:0] addr_wdata_i,
  input wire logic data_wr_i,
  input wire logic data_par_err_i,
  input wire logic data_rd_i,
  output logic [15:0] host_addr_o,
  output logic [7:0] host_rdata_o,
  // initialization limits
  input wire logic [afc_pkg::LIMIT_W-1:0] par_limit_i,
  input wire logic [afc_pkg::LIMIT_W-1:0] bus_limit_i,
  // dma read channel
  input wire logic rd_start_i,
  input wire logic rd_done_i,
  input wire logic rd_par_err_i,
  input wire logic rd_bus_err_i,
  input wire logic [31:0] rd_addr_i,
  // dma write channel
  input wire logic wr_start_i,
  input wire logic wr_done_i,
  input wire logic wr_par_err_i,
  input wire logic wr_bus_err_i,
  input wire logic [31:0] wr_addr_i,
  // internal processor
  input wire logic illegal_op_i,
  input wire logic [afc_pkg::BUS_PAR_SRCS-1:0] bus_par_err_i,
  input wire logic [15:0] proc_workspace_reg_a_i,
  input wire logic [15:0] proc_workspace_reg_b_i,
  input wire logic [15:0] proc_workspace_reg_c_i,
  // status toward the host and adapter
  output logic check_irq_o,
  output logic closed_o,
  output logic ssb_wr_en_o,
  output logic [15:0] fatal_check_cause_o
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1_r, rst_n_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ------------------------------------------------------------
  // dma watchdogs
  // ------------------------------------------------------------
  logic rd_abort, wr_abort;
  logic [15:0] rd_reason, wr_reason;
  logic [31:0] rd_fail_addr, wr_fail_addr;

  afc_dma_abort #(.TIMEOUT_CYC(DMA_TIMEOUT_CYC)) u_rd_abort (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .xfer_start_i(rd_start_i),
    .xfer_done_i(rd_done_i),
    .par_err_i(rd_par_err_i),
    .bus_err_i(rd_bus_err_i),
    .sys_addr_i(rd_addr_i),
    .par_limit_i(par_limit_i),
    .bus_limit_i(bus_limit_i),
    .abort_o(rd_abort),
    .reason_o(rd_reason),
    .addr_o(rd_fail_addr)
  );

  afc_dma_abort #(.TIMEOUT_CYC(DMA_TIMEOUT_CYC)) u_wr_abort (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .xfer_start_i(wr_start_i),
    .xfer_done_i(wr_done_i),
    .par_err_i(wr_par_err_i),
    .bus_err_i(wr_bus_err_i),
    .sys_addr_i(wr_addr_i),
    .par_limit_i(par_limit_i),
    .bus_limit_i(bus_limit_i),
    .abort_o(wr_abort),
    .reason_o(wr_reason),
    .addr_o(wr_fail_addr)
  );

  // ------------------------------------------------------------
  // check capture
  // ------------------------------------------------------------
  afc_pkg::afc_state_e state_r, state_nxt;
  logic [15:0] cause_r, cause_nxt;
  logic [15:0] p0_r, p0_nxt, p1_r, p1_nxt, p2_r, p2_nxt;
  logic irq_r, irq_nxt;
  // closed has its own flop so the pin is never a decode of the state
  logic closed_r, closed_nxt;
  logic [15:0] new_cause;
  logic any_fault;

  // only faults in the first faulting cycle of a check are reported; later faults cannot
  // overwrite the parameters the host is about to read
  always_comb begin
    new_cause = '0;
    new_cause[afc_pkg::CB_HOST_PARITY] = data_wr_i && data_par_err_i;
    new_cause[afc_pkg::CB_DMA_RD_ABORT] = rd_abort;
    new_cause[afc_pkg::CB_DMA_WR_ABORT] = wr_abort;
    new_cause[afc_pkg::CB_ILLEGAL_OP] = illegal_op_i;
    new_cause[afc_pkg::CB_BUS_PAR_HI:afc_pkg::CB_BUS_PAR_LO] = bus_par_err_i;
    any_fault = |new_cause;
    state_nxt = state_r;
    cause_nxt = cause_r;
    p0_nxt = p0_r;
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    irq_nxt = irq_r;
    closed_nxt = closed_r;
    unique case (state_r)
      afc_pkg::AFC_RUN: begin
        if (any_fault) begin
          state_nxt = afc_pkg::AFC_CHECKED;
          cause_nxt = new_cause;
          irq_nxt = 1'b1;
          closed_nxt = 1'b1;
          if (new_cause[afc_pkg::CB_DMA_RD_ABORT]) begin
            p0_nxt = rd_reason;
            p1_nxt = rd_fail_addr[31:16];
            p2_nxt = rd_fail_addr[15:0];
          end else if (new_cause[afc_pkg::CB_DMA_WR_ABORT]) begin
            p0_nxt = wr_reason;
            p1_nxt = wr_fail_addr[31:16];
            p2_nxt = wr_fail_addr[15:0];
          end else if (new_cause[afc_pkg::CB_BUS_PAR_HI:afc_pkg::CB_ILLEGAL_OP] != '0) begin
            p0_nxt = proc_workspace_reg_a_i;
            p1_nxt = proc_workspace_reg_b_i;
            p2_nxt = proc_workspace_reg_c_i;
          end else begin
            p0_nxt = afc_pkg::PARAM_RESET;
            p1_nxt = afc_pkg::PARAM_RESET;
            p2_nxt = afc_pkg::PARAM_RESET;
          end
        end
      end
      afc_pkg::AFC_CHECKED: begin
        state_nxt = afc_pkg::AFC_CHECKED;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= afc_pkg::AFC_RUN;
      cause_r <= afc_pkg::CAUSE_RESET;
      p0_r <= afc_pkg::PARAM_RESET;
      p1_r <= afc_pkg::PARAM_RESET;
      p2_r <= afc_pkg::PARAM_RESET;
      irq_r <= 1'b0;
      closed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      p0_r <= p0_nxt;
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      irq_r <= irq_nxt;
      closed_r <= closed_nxt;
    end
  end

  // ------------------------------------------------------------
  // host record port
  // ------------------------------------------------------------
  // record bytes: cause, p0, p1, p2 words, high byte first
  logic [63:0] record;
  logic [15:0] port_addr;
  logic [7:0] port_rdata;
  logic [15:0] hold_addr_r;
  logic [7:0] hold_rdata_r;

  assign record = {p2_r[7:0], p2_r[15:8], p1_r[7:0], p1_r[15:8],
                   p0_r[7:0], p0_r[15:8], cause_r[7:0], cause_r[15:8]};

  afc_rec_port u_port (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .addr_wr_i(addr_wr_i),
    .addr_wdata_i(addr_wdata_i),
    .data_rd_i(data_rd_i),
    .record_i(record),
    .addr_o(port_addr),
    .rdata_o(port_rdata)
  );

  // retimed so every top output except the constant ssb_wr_en_o leaves a local flip-flop
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_addr_r <= afc_pkg::ADDR_RESET;
      hold_rdata_r <= 8'h00;
    end else begin
      hold_addr_r <= port_addr;
      hold_rdata_r <= port_rdata;
    end
  end

  assign host_addr_o = hold_addr_r;
  assign host_rdata_o = hold_rdata_r;
  assign check_irq_o = irq_r;
  assign closed_o = closed_r;
  // status block writes are never granted by this unit
  assign ssb_wr_en_o = 1'b0;
  assign fatal_check_cause_o = cause_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_irq_on_fault: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (state_r == afc_pkg::AFC_RUN && any_fault) |=> check_irq_o && closed_o)
    else $error("fault did not raise check");
  chk_ssb_untouched: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    $rose(check_irq_o) |-> !ssb_wr_en_o)
    else $error("status block written on check");
  chk_stays_closed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    closed_o |=> closed_o && check_irq_o)
    else $error("left closed state without reset");
  chk_addr_incr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (data_rd_i && !addr_wr_i) |=> ##1 host_addr_o == $past(host_addr_o) + 16'h0001)
    else $error("address did not advance");
  chk_cause_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    closed_o |=> $stable(fatal_check_cause_o))
    else $error("cause changed after check");
  chk_host_parity: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && data_wr_i && data_par_err_i) |=> fatal_check_cause_o[0])
    else $error("host parity not reported");
  chk_rd_reason: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && rd_abort) |=> fatal_check_cause_o[1] && p0_r == $past(rd_reason)
      && {p1_r, p2_r} == $past(rd_fail_addr))
    else $error("read abort record wrong");
  chk_wr_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && wr_abort) |=> fatal_check_cause_o[2])
    else $error("write abort not reported");
  chk_illegal_op: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && illegal_op_i && !rd_abort && !wr_abort) |=> fatal_check_cause_o[3]
      && p0_r == $past(proc_workspace_reg_a_i))
    else $error("illegal opcode record wrong");
  chk_proc_parity: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && bus_par_err_i[0]) |=> fatal_check_cause_o[4])
    else $error("processor parity not in bit 4");
  chk_wr_record: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && wr_abort && !rd_abort) |=> p0_r == $past(wr_reason)
      && {p1_r, p2_r} == $past(wr_fail_addr))
    else $error("write abort record wrong");
  chk_illegal_params: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && illegal_op_i && !rd_abort && !wr_abort)
      |=> p1_r == $past(proc_workspace_reg_b_i) && p2_r == $past(proc_workspace_reg_c_i))
    else $error("illegal opcode parameters wrong");
  chk_bus_par_src: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && bus_par_err_i != '0 && !rd_abort && !wr_abort)
      |=> fatal_check_cause_o[afc_pkg::CB_BUS_PAR_HI:afc_pkg::CB_BUS_PAR_LO] == $past(bus_par_err_i)
      && p0_r == $past(proc_workspace_reg_a_i))
    else $error("internal parity record wrong");
  chk_host_par_params: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && data_wr_i && data_par_err_i && !rd_abort && !wr_abort && !illegal_op_i
      && bus_par_err_i == '0) |=> {p0_r, p1_r, p2_r} == '0)
    else $error("host parity parameters not zero");
  chk_no_false_check: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (!closed_o && !any_fault) |=> !check_irq_o && !closed_o)
    else $error("check raised without a fault");
  // ------------------------------------------------------------
  // record port checks
  // ------------------------------------------------------------
  chk_addr_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    addr_wr_i |=> ##1 host_addr_o == $past(addr_wdata_i, 2))
    else $error("address register not loaded");
  chk_first_byte: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    (closed_o && data_rd_i && !addr_wr_i && port_addr == afc_pkg::REC_BASE_ADDR)
      |=> ##1 host_rdata_o == cause_r[15:8])
    else $error("record does not open with cause high byte");
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [31:0] TMO = 32'h00000032;
  logic clk = 1'b0;
  logic reset_n, data_wr, data_par, rd_start, rd_done, rd_par, rd_bus;
  logic wr_start, wr_done, wr_par, wr_bus, illegal_op;
  logic [7:0] par_limit, bus_limit;
  logic [31:0] rd_addr, wr_addr;
  logic [5:0] bus_par;
  logic [15:0] ws_a, ws_b, ws_c;
  wire logic addr_wr, data_rd, irq, closed, ssb_wr;
  wire logic [15:0] addr_wdata, host_addr, cause;
  wire logic [7:0] rdata;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  afc_top #(.DMA_TIMEOUT_CYC(TMO)) dut_u (
    .ref_clk_i(clk), .reset_n_i(reset_n), .addr_wr_i(addr_wr),
    .addr_wdata_i(addr_wdata), .data_wr_i(data_wr), .data_par_err_i(data_par),
    .data_rd_i(data_rd), .host_addr_o(host_addr), .host_rdata_o(rdata),
    .par_limit_i(par_limit), .bus_limit_i(bus_limit), .rd_start_i(rd_start),
    .rd_done_i(rd_done), .rd_par_err_i(rd_par), .rd_bus_err_i(rd_bus),
    .rd_addr_i(rd_addr), .wr_start_i(wr_start), .wr_done_i(wr_done),
    .wr_par_err_i(wr_par), .wr_bus_err_i(wr_bus), .wr_addr_i(wr_addr),
    .illegal_op_i(illegal_op), .bus_par_err_i(bus_par),
    .proc_workspace_reg_a_i(ws_a), .proc_workspace_reg_b_i(ws_b),
    .proc_workspace_reg_c_i(ws_c), .check_irq_o(irq), .closed_o(closed),
    .ssb_wr_en_o(ssb_wr), .fatal_check_cause_o(cause));

  afc_host_model host_u (.clk_i(clk), .rdata_i(rdata), .addr_wr_o(addr_wr),
    .addr_wdata_o(addr_wdata), .data_rd_o(data_rd));

  task automatic wrap_up();
    $display("counts: cmp_count=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard: whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    {data_wr, data_par, rd_start, rd_done, rd_par, rd_bus} = '0;
    {wr_start, wr_done, wr_par, wr_bus, illegal_op, bus_par} = '0;
    par_limit = 8'h03;
    bus_limit = 8'h03;
    rd_addr = $urandom;
    wr_addr = $urandom;
    ws_a = 16'($urandom);
    ws_b = 16'($urandom);
    ws_c = 16'($urandom);
    tick(8);
    reset_n = 1'b1;
    tick(3);
    cmp1(closed, 1'b0, "open after reset");
    cmp16(cause, 16'h0000, "cause after reset");
  endtask

  // waits for the check, then compares the flags and the fetched record
  task automatic expect_check(input logic [15:0] c, input logic [15:0] p0,
                              input logic [15:0] p1, input logic [15:0] p2);
    logic [63:0] rec;
    int w[4];
    logic [7:0] q[$];
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    w = '{c, p0, p1, p2};
    foreach (w[i]) begin
      q.push_back(8'(w[i] >> 8));
      q.push_back(8'(w[i]));
    end
    cmp1(irq, 1'b1, "check irq");
    cmp1(closed, 1'b1, "closed");
    cmp1(ssb_wr, 1'b0, "status block write");
    cmp16(cause, c, "cause");
    host_u.fetch(rec);
    for (int i = 0; i < 8; i++) begin
      cmp16({8'h00, rec[63-8*i -: 8]}, {8'h00, q[i]}, "record byte");
    end
    cmp16(host_addr, afc_pkg::REC_BASE_ADDR + 16'h0008, "address after");
  endtask

  task automatic set_err(input int ch, input int r, input logic v);
    if (ch == 0 && r == 1) rd_par = v;
    if (ch == 0 && r == 2) rd_bus = v;
    if (ch == 1 && r == 1) wr_par = v;
    if (ch == 1 && r == 2) wr_bus = v;
  endtask

  // errors up to the limit are tolerated; one more aborts
  task automatic dma_err(input int ch, input int r);
    int lim;
    logic [31:0] a;
    do_reset();
    lim = $urandom_range(4, 1);
    a = $urandom;
    par_limit = 8'(lim);
    bus_limit = 8'(lim);
    rd_addr = a;
    wr_addr = a;
    if (ch == 0) rd_start = 1'b1;
    else wr_start = 1'b1;
    tick(1);
    {rd_start, wr_start} = '0;
    for (int i = 0; i <= lim; i++) begin
      set_err(ch, r, 1'b1);
      tick(1);
      set_err(ch, r, 1'b0);
      tick(1);
      if (i == lim - 1) cmp1(irq, 1'b0, "below limit");
    end
    expect_check(ch == 0 ? 16'h0002 : 16'h0004, 16'(r), a[31:16], a[15:0]);
    $display("test dma abort ch %0d reason %0d done", ch, r);
  endtask

  initial begin
    logic [31:0] a;
    logic [15:0] e0, e1, e2;
    void'($urandom(57));
    reset_n = 1'b0;
    do_reset();
    data_wr = 1'b1;
    tick(1);
    data_wr = 1'b0;
    tick(2);
    cmp1(irq, 1'b0, "good parity write");
    data_wr = 1'b1;
    data_par = 1'b1;
    tick(1);
    {data_wr, data_par} = '0;
    expect_check(16'h0001, 16'h0000, 16'h0000, 16'h0000);
    illegal_op = 1'b1;
    tick(1);
    illegal_op = 1'b0;
    tick(4);
    expect_check(16'h0001, 16'h0000, 16'h0000, 16'h0000);
    $display("test host parity done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int r = 1; r <= 2; r++) begin
        dma_err(ch, r);
      end
    end
    do_reset();
    rd_start = 1'b1;
    tick(1);
    rd_start = 1'b0;
    tick(3);
    rd_done = 1'b1;
    tick(1);
    rd_done = 1'b0;
    tick(70);
    cmp1(irq, 1'b0, "finished transfer");
    a = $urandom;
    wr_addr = a;
    wr_start = 1'b1;
    tick(1);
    wr_start = 1'b0;
    tick(40);
    cmp1(irq, 1'b0, "before timeout");
    expect_check(16'h0004, afc_pkg::ABORT_TIMEOUT, a[31:16], a[15:0]);
    $display("test timeout done");
    for (int k = -1; k < 6; k++) begin
      do_reset();
      {e0, e1, e2} = {ws_a, ws_b, ws_c};
      if (k < 0) illegal_op = 1'b1;
      else bus_par = 6'(1 << k);
      tick(1);
      illegal_op = 1'b0;
      bus_par = '0;
      {ws_a, ws_b, ws_c} = ~{e0, e1, e2};
      expect_check(k < 0 ? 16'h0008 : 16'(1 << (4 + k)), e0, e1, e2);
      $display("test processor cause %0d done", k);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
